// ---- vts_ctrl.sv ----
// Purpose: Host controller issuing transfer cycles and serial words to a video memory
// Assumes: Device pins sampled synchronously to mclk; software on Avalon-MM
// Notes: Refused commands set sticky error bits, cleared by writing one
`include "vts_regs.svh"

module vts_ctrl (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Memory strobes and address
    output logic ras_n,
    output logic cas_n,
    output logic transfer_output_strobe_n,
    output logic w_n,
    output logic function_select_line,
    output logic shift_port_output_enable_n,
    output logic [8:0] address_inputs,
    // Serial port
    output logic shift_clock,
    input wire logic [3:0] stream_data_lines_in,
    output logic [3:0] stream_data_lines_out,
    output logic stream_data_lines_oe_n,
    input wire logic split_half_indicator
);
    import vts_pkg::*;

    vts_ctrl_t q, d;
    logic sbusy;
    logic [3:0] srdata;
    logic busy_all;
    logic wr_blocked;
    logic wr_ok;
    logic [31:0] addr_word;
    logic [31:0] addr_wr;

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction : be_merge

    // Write-type operations select serial input
    function automatic logic is_write_op(input vts_op_t op);
        return (op == VTS_OP_NWRITE) || (op == VTS_OP_AWRITE) || (op == VTS_OP_PWRITE);
    endfunction : is_write_op

    vts_sclk u_sclk (
        .mclk(mclk),
        .reset_n(reset_n),
        .start(q.sstart),
        .dir_in(q.mode_in),
        .wdata(q.swdata),
        .busy(sbusy),
        .rdata(srdata),
        .shift_clock(shift_clock),
        .stream_data_lines_in(stream_data_lines_in),
        .stream_data_lines_out(stream_data_lines_out),
        .stream_data_lines_oe_n(stream_data_lines_oe_n)
    );

    // Bus handshake; serial and transfer never overlap
    assign busy_all = (q.st != VTS_IDLE) || sbusy || q.sstart;
    assign wr_blocked = avs_write && busy_all &&
                        (avs_address == `VTS_OFF_CMD || avs_address == `VTS_OFF_SDATA);
    assign avs_waitrequest = wr_blocked || (avs_read && !q.rd_pend);
    assign wr_ok = avs_write && !wr_blocked;
    assign avs_readdata = q.rdd;
    assign addr_word = {7'h00, q.tap, 7'h00, q.row};
    // Address word after a byte-lane write
    assign addr_wr = be_merge(addr_word, avs_writedata, avs_byteenable);

    // Next state of bus slave and transfer sequencer
    always_comb begin
        d = q;
        d.sstart = 1'b0;
        // Register reads, answered one cycle later from a flop
        d.rd_pend = avs_read && !q.rd_pend;
        if (avs_read && !q.rd_pend) begin
            unique case (avs_address)
                `VTS_OFF_ADDR: d.rdd = addr_word;
                `VTS_OFF_STATUS: begin
                    d.rdd = 32'h0;
                    d.rdd[`VTS_ST_BUSY] = busy_all;
                    d.rdd[`VTS_ST_MODE_IN] = q.mode_in;
                    d.rdd[`VTS_ST_HALF] = split_half_indicator;
                    d.rdd[`VTS_ST_NREAD] = q.nread_done;
                    d.rdd[`VTS_ST_SCSEEN] = q.sc_seen;
                    d.rdd[`VTS_ST_ERR_LSB +: 4] = q.err;
                end
                `VTS_OFF_SDATA: d.rdd = {28'h0, srdata};
                default: d.rdd = 32'h0;
            endcase
        end
        // Register writes
        if (wr_ok && avs_address == `VTS_OFF_ADDR) begin
            d.tap = addr_wr[24:16];
            d.row = addr_wr[8:0];
        end
        if (wr_ok && avs_address == `VTS_OFF_STATUS && avs_byteenable[1]) begin
            d.err = q.err & ~avs_writedata[`VTS_ST_ERR_LSB +: 4];
        end
        if (wr_ok && avs_address == `VTS_OFF_SDATA && avs_byteenable[0]) begin
            d.sstart = 1'b1;
            d.swdata = avs_writedata[3:0];
            d.sc_seen = 1'b1;
        end
        if (wr_ok && avs_address == `VTS_OFF_CMD && avs_byteenable[0]) begin
            d.op = vts_op_t'(avs_writedata[`VTS_CMD_OP_LSB +: 3]);
            d.dly = avs_writedata[`VTS_CMD_DLY_LSB +: 8];
            if (avs_writedata[`VTS_CMD_OP_LSB +: 3] > 3'h4) begin
                d.err[`VTS_ERR_BAD_OP] = 1'b1;
            end else if (avs_writedata[2:0] == 3'h4 && !q.nread_done) begin
                d.err[`VTS_ERR_NO_NREAD] = 1'b1;
            end else if (avs_writedata[2:0] == 3'h4 && !q.sc_seen) begin
                d.err[`VTS_ERR_NO_SC] = 1'b1;
            end else if (avs_writedata[2:0] == 3'h4 && q.tap[7:0] == 8'hFF) begin
                d.err[`VTS_ERR_BAD_TAP] = 1'b1;
            end else begin
                d.st = VTS_SETUP;
                d.tmr = `VTS_SCRL_CYC;
            end
        end
        // Transfer cycle sequence
        unique case (q.st)
            VTS_IDLE: begin
                d.xfer_n = 1'b1;
                d.spoe_n = 1'b0;
            end
            VTS_SETUP: begin
                d.xfer_n = 1'b0;
                d.w_n = !is_write_op(q.op);
                d.fsel = (q.op == VTS_OP_AWRITE) || (q.op == VTS_OP_SREAD);
                d.spoe_n = (q.op == VTS_OP_PWRITE);
                d.addr = q.row;
                d.tmr = q.tmr - 8'h1;
                if (q.tmr <= 8'h1) begin
                    d.st = VTS_RASL;
                end
            end
            VTS_RASL: begin
                d.ras_n = 1'b0;
                d.st = VTS_COL;
            end
            VTS_COL: begin
                // Column address settles a cycle before the column strobe
                d.addr = q.tap;
                d.tmr = (q.dly > `VTS_CAS_LOW_CYC) ? q.dly : `VTS_CAS_LOW_CYC;
                d.st = VTS_TRGW;
            end
            VTS_TRGW: begin
                // Strobe falls first; delay counts from that fall
                d.cas_n = 1'b0;
                if (!q.cas_n) begin
                    d.tmr = q.tmr - 8'h1;
                    if (q.tmr <= 8'h1) begin
                        d.xfer_n = 1'b1;
                        d.tmr = `VTS_RAS_LOW_CYC;
                        d.st = VTS_RASW;
                    end
                end
            end
            VTS_RASW: begin
                d.tmr = q.tmr - 8'h1;
                if (q.tmr <= 8'h1) begin
                    d.ras_n = 1'b1;
                    d.cas_n = 1'b1;
                    d.mode_in = is_write_op(q.op);
                    if (q.op == VTS_OP_NREAD) begin
                        d.nread_done = 1'b1;
                        d.sc_seen = 1'b1;
                    end else if (q.op == VTS_OP_SREAD) begin
                        d.sc_seen = 1'b0;
                    end else begin
                        d.nread_done = 1'b0;
                    end
                    d.tmr = (`VTS_RAS_HIGH_CYC > `VTS_RHSC_CYC) ? `VTS_RAS_HIGH_CYC
                                                                : `VTS_RHSC_CYC;
                    d.st = VTS_PRE;
                end
            end
            VTS_PRE: begin
                d.tmr = q.tmr - 8'h1;
                if (q.tmr <= 8'h1) begin
                    d.st = VTS_IDLE;
                end
            end
            default: begin
                d.st = VTS_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            q <= '{st: VTS_IDLE, tmr: 8'h00, op: VTS_OP_NWRITE, dly: `VTS_DLY_RST,
                   row: 9'h000, tap: 9'h000, mode_in: 1'b0, nread_done: 1'b0,
                   sc_seen: 1'b0, err: 4'h0, rd_pend: 1'b0, rdd: 32'h0000_0000,
                   sstart: 1'b0, swdata: 4'h0, ras_n: 1'b1, cas_n: 1'b1, xfer_n: 1'b1,
                   w_n: 1'b1, fsel: 1'b0, spoe_n: 1'b0, addr: 9'h000};
        end else begin
            q <= d;
        end
    end

    // Pin drivers from flops
    assign ras_n = q.ras_n;
    assign cas_n = q.cas_n;
    assign transfer_output_strobe_n = q.xfer_n;
    assign w_n = q.w_n;
    assign function_select_line = q.fsel;
    assign shift_port_output_enable_n = q.spoe_n;
    assign address_inputs = q.addr;

endmodule : vts_ctrl

// ---- vts_regs.svh ----
// Purpose: Register offsets, fields and timing counts of the transfer/serial controller
// Assumes: mclk at 40 MHz; byte addresses on the Avalon slave
// Notes: Times in ns, cycle counts derived from them
//
// Contract
// - Transfer strobe low before row strobe falls
// - Store select low writes, high reads
// - Serial clock quiet around write transfer
// - Enter input mode before clocking data in
// - Early, midline, late load via strobe release
// - Never use tap 255 or 511 split
// - Normal read first; shift edge between splits
// - Split without prior normal read undefined
`ifndef VTS_REGS_SVH
`define VTS_REGS_SVH

// Register byte offsets
`define VTS_OFF_CMD 4'h0
`define VTS_OFF_ADDR 4'h4
`define VTS_OFF_STATUS 4'h8
`define VTS_OFF_SDATA 4'hC

// CMD fields
`define VTS_CMD_OP_LSB 0
`define VTS_CMD_DLY_LSB 8
// ADDR fields
`define VTS_ADDR_ROW_LSB 0
`define VTS_ADDR_TAP_LSB 16
// STATUS fields
`define VTS_ST_BUSY 0
`define VTS_ST_MODE_IN 1
`define VTS_ST_HALF 2
`define VTS_ST_NREAD 3
`define VTS_ST_SCSEEN 4
`define VTS_ST_ERR_LSB 8

// Error bits
`define VTS_ERR_NO_NREAD 0
`define VTS_ERR_NO_SC 1
`define VTS_ERR_BAD_TAP 2
`define VTS_ERR_BAD_OP 3

// Reset values
`define VTS_ADDR_RST 32'h0000_0000
`define VTS_DLY_RST 8'h00

// Timing in ns
`define VTS_CLK_NS 25
`define VTS_T_RAS_LOW_NS 100
`define VTS_T_RAS_HIGH_NS 80
`define VTS_T_CAS_LOW_NS 25
`define VTS_T_SCRL_NS 25
`define VTS_T_RHSC_NS 25
`define VTS_T_SCK_ACC_NS 30
`define VTS_T_SCK_LOW_NS 10

// Least times round up to whole cycles
`define VTS_CYC_UP(ns) (((ns) + `VTS_CLK_NS - 1) / `VTS_CLK_NS)
`define VTS_RAS_LOW_CYC 8'(`VTS_CYC_UP(`VTS_T_RAS_LOW_NS))
`define VTS_RAS_HIGH_CYC 8'(`VTS_CYC_UP(`VTS_T_RAS_HIGH_NS))
`define VTS_CAS_LOW_CYC 8'(`VTS_CYC_UP(`VTS_T_CAS_LOW_NS))
`define VTS_SCRL_CYC 8'(`VTS_CYC_UP(`VTS_T_SCRL_NS))
`define VTS_RHSC_CYC 8'(`VTS_CYC_UP(`VTS_T_RHSC_NS))
`define VTS_SCK_HI_CYC 2'(`VTS_CYC_UP(`VTS_T_SCK_ACC_NS))
`define VTS_SCK_LO_CYC 2'(`VTS_CYC_UP(`VTS_T_SCK_LOW_NS))

`endif

// ---- vts_pkg.sv ----
// Purpose: Types of the transfer/serial controller
// Assumes: Used by vts_ctrl and vts_sclk
// Notes: State records are packed structs
package vts_pkg;

    // Transfer operations written to CMD
    typedef enum logic [2:0] {
        VTS_OP_NWRITE = 3'h0,
        VTS_OP_AWRITE = 3'h1,
        VTS_OP_PWRITE = 3'h2,
        VTS_OP_NREAD = 3'h3,
        VTS_OP_SREAD = 3'h4
    } vts_op_t;

    // Transfer cycle states, Gray along the path except PRE back to IDLE
    typedef enum logic [2:0] {
        VTS_IDLE = 3'h0,
        VTS_SETUP = 3'h1,
        VTS_RASL = 3'h3,
        VTS_COL = 3'h2,
        VTS_TRGW = 3'h6,
        VTS_RASW = 3'h7,
        VTS_PRE = 3'h5
    } vts_st_t;

    // Shift clock states
    typedef enum logic [1:0] {
        VTS_S_IDLE = 2'h0,
        VTS_S_SET = 2'h1,
        VTS_S_HI = 2'h3,
        VTS_S_LO = 2'h2
    } vts_sst_t;

    typedef struct packed {
        vts_st_t st;
        logic [7:0] tmr;
        vts_op_t op;
        logic [7:0] dly;
        logic [8:0] row;
        logic [8:0] tap;
        logic mode_in;
        logic nread_done;
        logic sc_seen;
        logic [3:0] err;
        logic rd_pend;
        logic [31:0] rdd;
        logic sstart;
        logic [3:0] swdata;
        logic ras_n;
        logic cas_n;
        logic xfer_n;
        logic w_n;
        logic fsel;
        logic spoe_n;
        logic [8:0] addr;
    } vts_ctrl_t;

    typedef struct packed {
        vts_sst_t st;
        logic [1:0] cnt;
        logic dir_in;
        logic sck;
        logic oe_n;
        logic [3:0] dout;
        logic [3:0] rdata;
    } vts_sclk_t;

endpackage : vts_pkg

// ---- vts_sclk.sv ----
// Purpose: One shift clock pulse moving one word on the stream lines
// Assumes: Device access from shift clock rise fits in the high phase
// Notes: Drives data only in input mode, during its own pulse
`include "vts_regs.svh"

module vts_sclk (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Request
    input wire logic start,
    input wire logic dir_in,
    input wire logic [3:0] wdata,
    output logic busy,
    output logic [3:0] rdata,
    // Stream pins
    output logic shift_clock,
    input wire logic [3:0] stream_data_lines_in,
    output logic [3:0] stream_data_lines_out,
    output logic stream_data_lines_oe_n
);
    import vts_pkg::*;

    vts_sclk_t q, d;

    // Pulse sequencing
    always_comb begin
        d = q;
        unique case (q.st)
            VTS_S_IDLE: begin
                if (start) begin
                    d.st = VTS_S_SET;
                    d.dir_in = dir_in;
                    d.dout = wdata;
                    d.oe_n = ~dir_in;
                end
            end
            VTS_S_SET: begin
                d.sck = 1'b1;
                d.cnt = `VTS_SCK_HI_CYC;
                d.st = VTS_S_HI;
            end
            VTS_S_HI: begin
                d.cnt = q.cnt - 2'h1;
                if (q.cnt == 2'h1) begin
                    d.sck = 1'b0;
                    if (!q.dir_in) begin
                        d.rdata = stream_data_lines_in;
                    end
                    d.cnt = `VTS_SCK_LO_CYC;
                    d.st = VTS_S_LO;
                end
            end
            VTS_S_LO: begin
                d.cnt = q.cnt - 2'h1;
                if (q.cnt == 2'h1) begin
                    d.oe_n = 1'b1;
                    d.st = VTS_S_IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            q <= '{st: VTS_S_IDLE, cnt: 2'h0, dir_in: 1'b0, sck: 1'b0, oe_n: 1'b1,
                   dout: 4'h0, rdata: 4'h0};
        end else begin
            q <= d;
        end
    end

    assign busy = (q.st != VTS_S_IDLE);
    assign rdata = q.rdata;
    assign shift_clock = q.sck;
    assign stream_data_lines_out = q.dout;
    assign stream_data_lines_oe_n = q.oe_n;

endmodule : vts_sclk

// ---- vts_ctrl_checker.sv ----
// Purpose: Pin assertions for vts_ctrl
// Assumes: One clock domain, synchronous reset
// Notes: Figures follow the transfer and serial pin walks
module vts_ctrl_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Memory pins
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic transfer_output_strobe_n,
    input wire logic w_n,
    input wire logic function_select_line,
    input wire logic shift_port_output_enable_n,
    input wire logic [8:0] address_inputs,
    // Serial pins
    input wire logic shift_clock,
    input wire logic stream_data_lines_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // Whole checker runs on mclk
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    property p_xfer_first;
        $fell(ras_n) |-> !transfer_output_strobe_n;
    endproperty
    property p_quiet_before;
        $fell(ras_n) |-> !$past(shift_clock) && stream_data_lines_oe_n;
    endproperty
    property p_pseudo;
        $fell(ras_n) && shift_port_output_enable_n |-> !w_n && !function_select_line;
    endproperty
    property p_col;
        $fell(cas_n) |-> $past(ras_n, 2) == 1'b0 && $stable(address_inputs);
    endproperty
    property p_release;
        $past(reset_n) && $rose(transfer_output_strobe_n) |-> !ras_n && !cas_n;
    endproperty
    property p_split_tap;
        $fell(cas_n) && w_n && function_select_line |-> address_inputs[7:0] != 8'hFF;
    endproperty
    property p_quiet;
        !ras_n |-> !shift_clock && stream_data_lines_oe_n;
    endproperty
    property p_resume;
        $rose(ras_n) |-> !shift_clock [*2];
    endproperty
    property p_pulse;
        $rose(shift_clock) |=> shift_clock ##1 !shift_clock;
    endproperty
    property p_drive;
        $rose(shift_clock) && !stream_data_lines_oe_n |-> !stream_data_lines_oe_n [*3];
    endproperty
    a_xfer_first: assert property (p_xfer_first) else $error("strobe order");
    a_quiet_before: assert property (p_quiet_before) else $error("clock near row");
    a_pseudo: assert property (p_pseudo) else $error("pseudo write kind");
    a_col: assert property (p_col) else $error("column latch");
    a_release: assert property (p_release) else $error("strobe release");
    a_split_tap: assert property (p_split_tap) else $error("split tap");
    a_quiet: assert property (p_quiet) else $error("serial in transfer");
    a_resume: assert property (p_resume) else $error("early resume");
    a_pulse: assert property (p_pulse) else $error("clock pulse width");
    a_drive: assert property (p_drive) else $error("data not held");
    c_split: cover property ($fell(cas_n) && w_n && function_select_line);
    c_pseudo: cover property ($fell(ras_n) && shift_port_output_enable_n);
    c_write: cover property ($rose(shift_clock) && !stream_data_lines_oe_n);
endmodule : vts_ctrl_checker

bind vts_ctrl vts_ctrl_checker i_chk (
    .mclk, .reset_n, .ras_n, .cas_n, .transfer_output_strobe_n, .w_n, .function_select_line,
    .shift_port_output_enable_n, .address_inputs, .shift_clock, .stream_data_lines_oe_n
);

// ---- vts_mem_model.sv ----
// Purpose: Behavioural video memory transfer and serial port
// Assumes: Strobes come from controller flops, glitch free
// Notes: Array starts as row plus column, four bits
module vts_mem_model (
    // Strobes and address
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic xstb_n,
    input wire logic w_n,
    input wire logic fsel,
    input wire logic spoe_n,
    input wire logic [8:0] addr,
    // Serial port
    input wire logic sclk,
    input wire logic [3:0] sdo,
    input wire logic oe_n,
    output logic [3:0] sdi,
    output logic half
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] arr [512][512];
    logic [3:0] shreg [512];
    logic [8:0] row, ptr, tap, jump;
    logic xfer, wr, fsl, spoe, mode_in, split, pend;
    // Power-up contents
    initial begin
        foreach (arr[r, c]) arr[r][c] = 4'(r + c);
        ptr = 9'h000;
        mode_in = 1'b0;
        split = 1'b0;
        pend = 1'b0;
        sdi = 4'h0;
        xfer = 1'b0;
    end
    // Latch transfer kind at row strobe fall
    always @(negedge ras_n) begin
        xfer = !xstb_n;
        wr = !w_n;
        fsl = fsel;
        spoe = spoe_n;
        row = addr;
    end
    // Column strobe: tap, write-type moves
    always @(negedge cas_n) begin
        tap = addr;
        if (xfer && wr) begin
            if (fsl || !spoe) foreach (shreg[i]) arr[row][i] = shreg[i];
            ptr = addr;
            mode_in = 1'b1;
            split = 1'b0;
        end
    end
    // Read load at transfer strobe release
    always @(posedge xstb_n) begin
        if (xfer && !wr && !ras_n) begin
            mode_in = 1'b0;
            if (!fsl) begin
                foreach (shreg[i]) shreg[i] = arr[row][i];
                ptr = tap;
                split = 1'b0;
            end else begin
                for (int i = 0; i < 256; i++) shreg[{tap[8], 8'(i)}] = arr[row][{tap[8], 8'(i)}];
                jump = tap;
                split = 1'b1;
                pend = 1'b1;
            end
        end
    end
    // Shift clock: one word, then step the pointer
    always @(posedge sclk) begin
        if (mode_in) shreg[ptr] = oe_n ? ~sdi : sdo;
        sdi = mode_in ? ~sdi : shreg[ptr];
        if (split && ptr[7:0] == 8'hFF) begin
            ptr = pend ? jump : {~ptr[8], 8'h00};
            pend = 1'b0;
        end else begin
            ptr = ptr + 9'h001;
        end
    end
    assign half = ptr[8];
endmodule : vts_mem_model

// ---- vts_ctrl_tb.sv ----
// Purpose: Self-checking bench for vts_ctrl
// Assumes: Memory model on the pins, Avalon master tasks
// Notes: Expected words follow the model's row plus column fill
`include "vts_regs.svh"
module vts_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import vts_pkg::*;
    logic mclk, reset_n, avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_address, sdi, sdo;
    logic [31:0] avs_writedata, avs_readdata, rd, st;
    logic ras_n, cas_n, xstb_n, w_n, fsel, spoe_n, sclk, oe_n, half;
    logic [8:0] addr;
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    vts_ctrl i_dut (
        .mclk(mclk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ras_n(ras_n),
        .cas_n(cas_n), .transfer_output_strobe_n(xstb_n), .w_n(w_n),
        .function_select_line(fsel), .shift_port_output_enable_n(spoe_n),
        .address_inputs(addr), .shift_clock(sclk), .stream_data_lines_in(sdi),
        .stream_data_lines_out(sdo), .stream_data_lines_oe_n(oe_n), .split_half_indicator(half)
    );
    vts_mem_model i_mem (
        .ras_n(ras_n), .cas_n(cas_n), .xstb_n(xstb_n), .w_n(w_n), .fsel(fsel),
        .spoe_n(spoe_n), .addr(addr), .sclk(sclk), .sdo(sdo), .oe_n(oe_n), .sdi(sdi), .half(half)
    );
    // Clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Watchdog on stuck handshakes
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count = bad_count + 1;
            end_sim();
        end
    end
    task automatic end_sim();
        if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            bad_count = bad_count + 1;
        end
    endtask : chk
    // Avalon master: hold until waitrequest low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge mclk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do @(posedge mclk);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic idle();
        do bus(1'b0, `VTS_OFF_STATUS, 32'h0, st);
        while (st[`VTS_ST_BUSY] !== 1'b0);
    endtask : idle
    task automatic cmd(input logic [2:0] op, input logic [8:0] row, input logic [8:0] tap,
                       input logic [7:0] dl);
        bus(1'b1, `VTS_OFF_ADDR, {7'h00, tap, 7'h00, row}, rd);
        bus(1'b1, `VTS_OFF_CMD, {16'h0000, dl, 5'h00, op}, rd);
        idle();
    endtask : cmd
    // One shift clock; captured word lands in rd
    task automatic sh(input logic [3:0] d);
        bus(1'b1, `VTS_OFF_SDATA, {28'h0, d}, rd);
        idle();
        bus(1'b0, `VTS_OFF_SDATA, 32'h0, rd);
    endtask : sh
    task automatic refuse(input logic [2:0] op, input logic [8:0] tap, input logic [3:0] e);
        cmd(op, 9'h007, tap, 8'h01);
        chk(32'(st[11:8]), 32'(e));
        bus(1'b1, `VTS_OFF_STATUS, 32'h0000_0F00, rd);
    endtask : refuse
    task automatic t_reset();
        chk(32'({ras_n, cas_n, xstb_n, w_n, spoe_n, sclk, oe_n}), 32'h79);
        bus(1'b0, 4'h2, 32'h0, rd);
        chk(rd, 32'h0);
        refuse(VTS_OP_SREAD, 9'h010, 4'h1);
    endtask : t_reset
    task automatic t_nread();
        cmd(VTS_OP_NREAD, 9'h005, 9'h1FE, 8'h01);
        chk(32'(st[3:1]), 32'h6);
        for (int i = 0; i < 3; i++) begin
            sh(4'h0);
            chk(32'(rd[3:0]), 32'(4'(5 + 'h1FE + i)));
        end
        chk(32'(st[2]), 32'h0);
    endtask : t_nread
    task automatic t_split();
        cmd(VTS_OP_NREAD, 9'h005, 9'h0FE, 8'h03);
        cmd(VTS_OP_SREAD, 9'h006, 9'h120, 8'h03);
        chk(32'(st[11:8]), 32'h0);
        sh(4'h0);
        chk(32'(rd[3:0]), 32'h3);
        sh(4'h0);
        chk(32'(rd[3:0]), 32'h4);
        sh(4'h0);
        chk(32'(rd[3:0]), 32'h6);
        chk(32'(st[2]), 32'h1);
        cmd(VTS_OP_SREAD, 9'h007, 9'h030, 8'h01);
        refuse(VTS_OP_SREAD, 9'h040, 4'h2);
        sh(4'h0);
        refuse(VTS_OP_SREAD, 9'h0FF, 4'h4);
        refuse(3'h5, 9'h000, 4'h8);
    endtask : t_split
    task automatic t_write();
        for (int k = 0; k < 2; k++) begin
            cmd(VTS_OP_PWRITE, 9'h1F0, 9'h010, 8'h01);
            chk(32'(st[3:1]), 32'h1);
            sh(4'hA + 4'(k));
            sh(4'h5);
            cmd(k ? VTS_OP_AWRITE : VTS_OP_NWRITE, 9'(9 + k), 9'h020, 8'h01);
            chk(32'(st[3:1]), 32'h1);
            cmd(VTS_OP_NREAD, 9'(9 + k), 9'h010, 8'h08);
            sh(4'h0);
            chk(32'(rd[3:0]), 32'(4'hA + 4'(k)));
            sh(4'h0);
            chk(32'(rd[3:0]), 32'h5);
        end
    endtask : t_write
    // Main sequence
    initial begin
        reset_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        t_reset();
        t_nread();
        t_split();
        t_write();
        end_sim();
    end
endmodule : vts_ctrl_tb
